// >>> bench/irq_bank_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "irq_bank_consts.vh"

module irq_bank_props
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // bus side
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`APB_DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // sources and pending requests
    input wire logic timer_one_set,
    input wire logic [`REG_W-1:0] pending_0,
    input wire logic [`REG_W-1:0] pending_1,
    input wire logic [`REG_W-1:0] pending_4
);
    // ----------------------------------------
    // common clocking and completed writes
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire logic wr_done = psel && penable && pwrite && pready;

    // ----------------------------------------
    // bus answer timing and upper read data
    // ----------------------------------------
    AST_READY_NEXT: assert property (psel && !penable |=> pready)
        else $error("ready missing after setup");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("error without ready");
    AST_UPPER_ZERO: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
        else $error("upper read data not zero");

    // ----------------------------------------
    // pending requests
    // ----------------------------------------
    AST_W0W1_UNIMPL: assert property (
        ((pending_0 & ~`IMPL_WORD_0) | (pending_1 & ~`IMPL_WORD_1)) == 16'h0000)
        else $error("unused position pending");
    AST_W4_ONLY_BIT1: assert property ((pending_4 & 16'hFFFD) == 16'h0000)
        else $error("word four pending outside bit one");
    AST_NO_HW_CLEAR: assert property (
        |(~pending_0 & $past(pending_0)) |-> $past(wr_done, 2))
        else $error("request dropped without a write");
    AST_RISE_CAUSE: assert property (
        $rose(pending_0[`BIT_TIMER_ONE]) |-> $past(timer_one_set, 2) || $past(wr_done, 2))
        else $error("request rose without cause");
endmodule

`default_nettype wire

// >>> bench/periph_model.sv
`timescale 1ns/1ps
`default_nettype none

module periph_model
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // event request from the bench
    input wire logic fire,
    input wire logic [1:0] fire_word,
    input wire logic [3:0] fire_bit,
    // source lines by flag position, strobes and pin levels alike
    output logic [15:0] src0,
    output logic [15:0] src1,
    output logic [15:0] src4
);
    logic [2:0] hold_q;

    // raise one source for five cycles so pins pass the synchroniser
    always @(posedge clock)
    begin
        if (!rst_n || (!fire && hold_q == 3'h0))
        begin
            hold_q <= 3'h0;
            src0 <= 16'h0000;
            src1 <= 16'h0000;
            src4 <= 16'h0000;
        end
        else if (fire)
        begin
            hold_q <= 3'h4;
            src0 <= (fire_word == 2'h0) ? (16'h0001 << fire_bit) : 16'h0000;
            src1 <= (fire_word == 2'h1) ? (16'h0001 << fire_bit) : 16'h0000;
            src4 <= (fire_word == 2'h2) ? (16'h0001 << fire_bit) : 16'h0000;
        end
        else
            hold_q <= hold_q - 3'h1;
    end
endmodule

`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "irq_bank_consts.vh"

module tb_top;
    logic clock, rst_n, psel, penable, pwrite, fire, rerr;
    logic [7:0] paddr;
    logic [31:0] pwdata, rdat;
    logic [1:0] fire_word;
    logic [3:0] fire_bit;
    logic [15:0] m;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, irq;
    wire logic [15:0] pending_0, pending_1, pending_4, src0, src1, src4;
    int bad_count, checks_done, cycles;

    // ----------------------------------------
    // design and source model
    // ----------------------------------------
    interrupt_flag_enable_bank DUT (.clock(clock), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .adc_done_set(src0[13]), .serial_tx_set(src0[12]), .serial_rx_set(src0[11]),
        .sspi_event_set(src0[10]), .sspi_fault_set(src0[9]), .timer_three_set(src0[8]),
        .timer_two_set(src0[7]), .compare_two_set(src0[6]), .capture_two_set(src0[5]),
        .timer_one_set(src0[3]), .compare_one_set(src0[2]), .capture_one_set(src0[1]),
        .capture_eight_set(src1[7]), .capture_seven_set(src1[6]),
        .pin_change_set(src1[3]), .twowire_master_set(src1[1]),
        .twowire_slave_set(src1[0]), .serial_error_set(src4[1]),
        .ext_irq_zero_pin(src0[0]), .ext_irq_one_pin(src1[4]), .ext_irq_two_pin(src1[13]),
        .pending_0(pending_0), .pending_1(pending_1), .pending_4(pending_4), .irq(irq));
    periph_model u_src (.clock(clock), .rst_n(rst_n), .fire(fire), .fire_word(fire_word),
        .fire_bit(fire_bit), .src0(src0), .src1(src1), .src4(src4));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [15:0] impl(input int w);
        return (w == 0) ? `IMPL_WORD_0 : (w == 1) ? `IMPL_WORD_1 : `IMPL_WORD_4;
    endfunction
    function automatic logic [15:0] pend(input int w);
        return (w == 0) ? pending_0 : (w == 1) ? pending_1 : pending_4;
    endfunction
    // one apb transfer, held until ready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(n, e, rdat);
    endtask
    // fire one source and let the pin path settle
    task automatic pulse(input int w, input int b);
        @(posedge clock);
        fire <= 1'b1;
        fire_word <= w[1:0];
        fire_bit <= b[3:0];
        @(posedge clock);
        fire <= 1'b0;
        repeat (10) @(posedge clock);
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // clock, timeout and test sequence
    // ----------------------------------------
    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            bad_count++;
            $display("ERROR timeout expected done seen hung");
            end_sim;
        end
    end
    initial
    begin
        {rst_n, psel, penable, pwrite, fire} = 5'h00;
        {paddr, pwdata, fire_word, fire_bit} = 46'h0;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        for (int w = 0; w < 6; w++) rdchk("reset word", 8'(4 * w), 32'h0000_0000);
        $display("test reset values done");
        for (int w = 0; w < 3; w++)
        begin
            apb(1'b1, 8'(4 * w), 32'hFFFF_FFFF);
            apb(1'b1, 8'(12 + 4 * w), 32'hFFFF_FFFF);
            rdchk("flag word", 8'(4 * w), {16'h0000, impl(w)});
            rdchk("enable word", 8'(12 + 4 * w), {16'h0000, impl(w)});
            repeat (3) @(posedge clock);
            chk("pending written", {16'h0000, impl(w)}, {16'h0000, pend(w)});
            apb(1'b1, 8'(12 + 4 * w), 32'h0000_0000);
            repeat (3) @(posedge clock);
            chk("pending blocked", 32'h0000_0000, {16'h0000, pend(w)});
            apb(1'b1, 8'(4 * w), 32'h0000_0000);
            rdchk("flag cleared", 8'(4 * w), 32'h0000_0000);
            apb(1'b1, 8'(12 + 4 * w), 32'hFFFF_FFFF);
        end
        $display("test software access done");
        for (int w = 0; w < 3; w++)
        begin
            m = impl(w);
            for (int b = 0; b < 16; b++)
            begin
                if (m[b])
                begin
                    pulse(w, b);
                    rdchk("source flag", 8'(4 * w), 32'h0000_0001 << b);
                    chk("source pending", 32'h0000_0001 << b, {16'h0000, pend(w)});
                    apb(1'b1, 8'(4 * w), 32'h0000_0000);
                end
            end
        end
        // a strobe still high at the edge of a clearing write keeps its flag
        @(posedge clock);
        fire <= 1'b1;
        fire_word <= 2'h0;
        fire_bit <= 4'h3;
        @(posedge clock);
        fire <= 1'b0;
        repeat (2) @(posedge clock);
        apb(1'b1, 8'h00, 32'h0000_0000);
        rdchk("set beats clear", 8'h00, 32'h0000_0008);
        apb(1'b1, 8'h00, 32'h0000_0000);
        $display("test source events done");
        apb(1'b1, `OFF_EVT_STATUS, 32'h0000_0003);
        apb(1'b1, `OFF_EVT_MASK, 32'h0000_0002);
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk("unmapped error", 32'h0000_0001, {31'h0, rerr});
        chk("unmapped data", 32'h0000_0000, rdat);
        repeat (3) @(posedge clock);
        chk("irq raised", 32'h0000_0001, {31'h0, irq});
        apb(1'b1, `OFF_EVT_STATUS, 32'h0000_0003);
        repeat (3) @(posedge clock);
        chk("irq cleared", 32'h0000_0000, {31'h0, irq});
        apb(1'b1, `OFF_EVT_MASK, 32'h0000_0000);
        apb(1'b0, 8'h40, 32'h0000_0000);
        repeat (3) @(posedge clock);
        chk("irq masked", 32'h0000_0000, {31'h0, irq});
        rdchk("event status", `OFF_EVT_STATUS, 32'h0000_0002);
        $display("test interrupt done");
        end_sim;
    end
endmodule

bind interrupt_flag_enable_bank irq_bank_props u_props (.clock, .rst_n, .psel, .penable,
    .pwrite, .prdata, .pready, .pslverr, .timer_one_set, .pending_0, .pending_1, .pending_4);

`default_nettype wire

// >>> hw/interrupt_flag_enable_bank.v
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "irq_bank_consts.vh"

module interrupt_flag_enable_bank
(
    // clock and reset
    input wire clock,
    input wire rst_n,
    // apb slave port
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`APB_ADDR_W-1:0] paddr,
    input wire [`APB_DATA_W-1:0] pwdata,
    output reg [`APB_DATA_W-1:0] prdata,
    output reg pready,
    output reg pslverr,
    // on-chip set strobes, one-cycle pulses or levels
    input wire adc_done_set,
    input wire serial_tx_set,
    input wire serial_rx_set,
    input wire sspi_event_set,
    input wire sspi_fault_set,
    input wire timer_three_set,
    input wire timer_two_set,
    input wire compare_two_set,
    input wire capture_two_set,
    input wire timer_one_set,
    input wire compare_one_set,
    input wire capture_one_set,
    input wire capture_eight_set,
    input wire capture_seven_set,
    input wire pin_change_set,
    input wire twowire_master_set,
    input wire twowire_slave_set,
    input wire serial_error_set,
    // external interrupt pins, asynchronous
    input wire ext_irq_zero_pin,
    input wire ext_irq_one_pin,
    input wire ext_irq_two_pin,
    // pending requests toward priority logic
    output reg [`REG_W-1:0] pending_0,
    output reg [`REG_W-1:0] pending_1,
    output reg [`REG_W-1:0] pending_4,
    // block interrupt
    output reg irq
);

// ------------------------------------------------------------
// address decode
// ------------------------------------------------------------

// maps a byte address to a register index, unaligned or unknown to none
function [3:0] reg_index;
    input [`APB_ADDR_W-1:0] addr;
    begin
        case (addr)
            `OFF_FLAGS_0: reg_index = `IDX_FLAGS_0;
            `OFF_FLAGS_1: reg_index = `IDX_FLAGS_1;
            `OFF_FLAGS_4: reg_index = `IDX_FLAGS_4;
            `OFF_ENABLES_0: reg_index = `IDX_ENABLES_0;
            `OFF_ENABLES_1: reg_index = `IDX_ENABLES_1;
            `OFF_ENABLES_4: reg_index = `IDX_ENABLES_4;
            `OFF_EVT_STATUS: reg_index = `IDX_EVT_STATUS;
            `OFF_EVT_MASK: reg_index = `IDX_EVT_MASK;
            default: reg_index = `IDX_NONE;
        endcase
    end
endfunction

// implemented-bit mask for one storage word
function [`REG_W-1:0] word_impl;
    input integer k;
    begin
        case (k)
            0: word_impl = `IMPL_WORD_0;
            1: word_impl = `IMPL_WORD_1;
            2: word_impl = `IMPL_WORD_4;
            3: word_impl = `IMPL_WORD_0;
            4: word_impl = `IMPL_WORD_1;
            5: word_impl = `IMPL_WORD_4;
            default: word_impl = `RESET_WORD;
        endcase
    end
endfunction

// register index that writes one storage word
function [3:0] word_index;
    input integer k;
    begin
        case (k)
            0: word_index = `IDX_FLAGS_0;
            1: word_index = `IDX_FLAGS_1;
            2: word_index = `IDX_FLAGS_4;
            3: word_index = `IDX_ENABLES_0;
            4: word_index = `IDX_ENABLES_1;
            5: word_index = `IDX_ENABLES_4;
            default: word_index = `IDX_NONE;
        endcase
    end
endfunction

wire setup_phase;
wire access_done;
wire wr_fire;
wire [3:0] idx;

assign setup_phase = psel & ~penable;
assign access_done = psel & penable & pready;
assign wr_fire = access_done & pwrite & ~pslverr;
assign idx = reg_index(paddr);

// ------------------------------------------------------------
// external pin edges
// ------------------------------------------------------------
wire [2:0] ext_pins;
wire [2:0] ext_rise;

assign ext_pins = {ext_irq_two_pin, ext_irq_one_pin, ext_irq_zero_pin};

// synchronise each pin and catch its rising edge
genvar p;
generate
    for (p = 0; p < 3; p = p + 1)
    begin : g_pin
        irq_pin_sync u_sync
        (
            .clock(clock),
            .rst_n(rst_n),
            .pin(ext_pins[p]),
            .rise(ext_rise[p])
        );
    end
endgenerate

// ------------------------------------------------------------
// hardware set vectors
// ------------------------------------------------------------
reg [`REG_W-1:0] set_0;
reg [`REG_W-1:0] set_1;
reg [`REG_W-1:0] set_4;

// place each source at its documented bit
always @*
begin
    set_0 = `RESET_WORD;
    set_1 = `RESET_WORD;
    set_4 = `RESET_WORD;
    set_0[`BIT_ADC_DONE] = adc_done_set;
    set_0[`BIT_SERIAL_TX] = serial_tx_set;
    set_0[`BIT_SERIAL_RX] = serial_rx_set;
    set_0[`BIT_SSPI_EVENT] = sspi_event_set;
    set_0[`BIT_SSPI_FAULT] = sspi_fault_set;
    set_0[`BIT_TIMER_THREE] = timer_three_set;
    set_0[`BIT_TIMER_TWO] = timer_two_set;
    set_0[`BIT_COMPARE_TWO] = compare_two_set;
    set_0[`BIT_CAPTURE_TWO] = capture_two_set;
    set_0[`BIT_TIMER_ONE] = timer_one_set;
    set_0[`BIT_COMPARE_ONE] = compare_one_set;
    set_0[`BIT_CAPTURE_ONE] = capture_one_set;
    set_0[`BIT_EXT_IRQ_ZERO] = ext_rise[0];
    set_1[`BIT_EXT_IRQ_TWO] = ext_rise[2];
    set_1[`BIT_CAPTURE_EIGHT] = capture_eight_set;
    set_1[`BIT_CAPTURE_SEVEN] = capture_seven_set;
    set_1[`BIT_EXT_IRQ_ONE] = ext_rise[1];
    set_1[`BIT_PIN_CHANGE] = pin_change_set;
    set_1[`BIT_TWOWIRE_MASTER] = twowire_master_set;
    set_1[`BIT_TWOWIRE_SLAVE] = twowire_slave_set;
    set_4[`BIT_SERIAL_ERROR] = serial_error_set;
end

// ------------------------------------------------------------
// flag and enable storage
// ------------------------------------------------------------
wire [`REG_W*`NUM_WORDS-1:0] set_all;
wire [`REG_W*`NUM_WORDS-1:0] word_q;
wire [`REG_W-1:0] wr_word;

// enables have no hardware set, only software writes
assign set_all = {{(`REG_W*3){1'b0}}, set_4, set_1, set_0};
assign wr_word = pwdata[`REG_W-1:0];

// words 0..2 are flags, 3..5 the matching enables
genvar w;
generate
    for (w = 0; w < `NUM_WORDS; w = w + 1)
    begin : g_word
        irq_flag_word
        #(
            .IMPL(word_impl(w))
        )
        u_word
        (
            .clock(clock),
            .rst_n(rst_n),
            .wr_en(wr_fire & (idx == word_index(w))),
            .wr_data(wr_word),
            .set_vec(set_all[w*`REG_W +: `REG_W]),
            .value(word_q[w*`REG_W +: `REG_W])
        );
    end
endgenerate

wire [`REG_W-1:0] flags_0;
wire [`REG_W-1:0] flags_1;
wire [`REG_W-1:0] flags_4;
wire [`REG_W-1:0] enables_0;
wire [`REG_W-1:0] enables_1;
wire [`REG_W-1:0] enables_4;

// named views of the storage words
assign flags_0 = word_q[0*`REG_W +: `REG_W];
assign flags_1 = word_q[1*`REG_W +: `REG_W];
assign flags_4 = word_q[2*`REG_W +: `REG_W];
assign enables_0 = word_q[3*`REG_W +: `REG_W];
assign enables_1 = word_q[4*`REG_W +: `REG_W];
assign enables_4 = word_q[5*`REG_W +: `REG_W];

// ------------------------------------------------------------
// pending requests
// ------------------------------------------------------------
wire [`REG_W-1:0] pend_0_d;
wire [`REG_W-1:0] pend_1_d;
wire [`REG_W-1:0] pend_4_d;
wire new_pending;

// a source pends only with flag and enable both set
assign pend_0_d = flags_0 & enables_0;
assign pend_1_d = flags_1 & enables_1;
assign pend_4_d = flags_4 & enables_4;
assign new_pending = |({pend_4_d, pend_1_d, pend_0_d}
    & ~{pending_4, pending_1, pending_0});

// register pending words toward the priority logic
always @(posedge clock)
begin
    if (!rst_n)
    begin
        pending_0 <= `RESET_WORD;
        pending_1 <= `RESET_WORD;
        pending_4 <= `RESET_WORD;
    end
    else
    begin
        pending_0 <= pend_0_d;
        pending_1 <= pend_1_d;
        pending_4 <= pend_4_d;
    end
end

// ------------------------------------------------------------
// block event status, mask and interrupt
// ------------------------------------------------------------
reg [`EVT_W-1:0] evt_status_q;
reg [`EVT_W-1:0] evt_status_d;
reg [`EVT_W-1:0] evt_mask_q;
reg [`EVT_W-1:0] evt_set;
reg [`EVT_W-1:0] evt_clr;

// sticky status: events set, write-one clears, set wins
always @*
begin
    evt_set = `RESET_EVT;
    evt_set[`EVT_NEW_PENDING] = new_pending;
    evt_set[`EVT_BUS_ERROR] = access_done & pslverr;
    evt_clr = `RESET_EVT;
    if (wr_fire && idx == `IDX_EVT_STATUS)
        evt_clr = pwdata[`EVT_W-1:0];
    evt_status_d = (evt_status_q & ~evt_clr) | evt_set;
end

// status, mask and level interrupt output
always @(posedge clock)
begin
    if (!rst_n)
    begin
        evt_status_q <= `RESET_EVT;
        evt_mask_q <= `RESET_EVT;
        irq <= 1'b0;
    end
    else
    begin
        evt_status_q <= evt_status_d;
        if (wr_fire && idx == `IDX_EVT_MASK)
            evt_mask_q <= pwdata[`EVT_W-1:0];
        irq <= |(evt_status_q & evt_mask_q);
    end
end

// ------------------------------------------------------------
// read data
// ------------------------------------------------------------
reg [`APB_DATA_W-1:0] rd_value;

// select the addressed register, upper bits zero
always @*
begin
    rd_value = `RESET_BUS;
    case (idx)
        `IDX_FLAGS_0: rd_value[`REG_W-1:0] = flags_0;
        `IDX_FLAGS_1: rd_value[`REG_W-1:0] = flags_1;
        `IDX_FLAGS_4: rd_value[`REG_W-1:0] = flags_4;
        `IDX_ENABLES_0: rd_value[`REG_W-1:0] = enables_0;
        `IDX_ENABLES_1: rd_value[`REG_W-1:0] = enables_1;
        `IDX_ENABLES_4: rd_value[`REG_W-1:0] = enables_4;
        `IDX_EVT_STATUS: rd_value[`EVT_W-1:0] = evt_status_q;
        `IDX_EVT_MASK: rd_value[`EVT_W-1:0] = evt_mask_q;
        default: rd_value = `RESET_BUS;
    endcase
end

// ------------------------------------------------------------
// apb handshake: ready in the first access cycle
// ------------------------------------------------------------
always @(posedge clock)
begin
    if (!rst_n)
    begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= `RESET_BUS;
    end
    else
    begin
        pready <= setup_phase;
        pslverr <= setup_phase & (idx == `IDX_NONE);
        if (setup_phase)
            prdata <= pwrite ? `RESET_BUS : rd_value;
    end
end

endmodule

`default_nettype wire

// >>> hw/irq_bank_consts.vh
`ifndef IRQ_BANK_CONSTS_VH
`define IRQ_BANK_CONSTS_VH

// ------------------------------------------------------------
// bus and word geometry
// ------------------------------------------------------------
`define APB_ADDR_W 8
`define APB_DATA_W 32
`define REG_W 16
`define NUM_WORDS 6
`define RESET_WORD 16'h0000
`define RESET_BUS 32'h0000_0000

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define OFF_FLAGS_0 8'h00
`define OFF_FLAGS_1 8'h04
`define OFF_FLAGS_4 8'h08
`define OFF_ENABLES_0 8'h0C
`define OFF_ENABLES_1 8'h10
`define OFF_ENABLES_4 8'h14
`define OFF_EVT_STATUS 8'h18
`define OFF_EVT_MASK 8'h1C

// ------------------------------------------------------------
// decoded register indices
// ------------------------------------------------------------
`define IDX_FLAGS_0 4'h0
`define IDX_FLAGS_1 4'h1
`define IDX_FLAGS_4 4'h2
`define IDX_ENABLES_0 4'h3
`define IDX_ENABLES_1 4'h4
`define IDX_ENABLES_4 4'h5
`define IDX_EVT_STATUS 4'h6
`define IDX_EVT_MASK 4'h7
`define IDX_NONE 4'hF

// ------------------------------------------------------------
// implemented bit masks per word
// ------------------------------------------------------------
`define IMPL_WORD_0 16'h3FEF
`define IMPL_WORD_1 16'h20DB
`define IMPL_WORD_4 16'h0002

// ------------------------------------------------------------
// source bit positions, word 0
// ------------------------------------------------------------
`define BIT_ADC_DONE 13
`define BIT_SERIAL_TX 12
`define BIT_SERIAL_RX 11
`define BIT_SSPI_EVENT 10
`define BIT_SSPI_FAULT 9
`define BIT_TIMER_THREE 8
`define BIT_TIMER_TWO 7
`define BIT_COMPARE_TWO 6
`define BIT_CAPTURE_TWO 5
`define BIT_TIMER_ONE 3
`define BIT_COMPARE_ONE 2
`define BIT_CAPTURE_ONE 1
`define BIT_EXT_IRQ_ZERO 0

// ------------------------------------------------------------
// source bit positions, words 1 and 4
// ------------------------------------------------------------
`define BIT_EXT_IRQ_TWO 13
`define BIT_CAPTURE_EIGHT 7
`define BIT_CAPTURE_SEVEN 6
`define BIT_EXT_IRQ_ONE 4
`define BIT_PIN_CHANGE 3
`define BIT_TWOWIRE_MASTER 1
`define BIT_TWOWIRE_SLAVE 0
`define BIT_SERIAL_ERROR 1

// ------------------------------------------------------------
// block event status bits
// ------------------------------------------------------------
`define EVT_W 2
`define EVT_NEW_PENDING 0
`define EVT_BUS_ERROR 1
`define RESET_EVT 2'h0

`endif

// >>> hw/irq_flag_word.v
`timescale 1ns/1ps
`default_nettype none
`include "irq_bank_consts.vh"

module irq_flag_word
#(
    parameter [15:0] IMPL = 16'hFFFF
)
(
    // clock and reset
    input wire clock,
    input wire rst_n,
    // software write
    input wire wr_en,
    input wire [15:0] wr_data,
    // hardware set requests
    input wire [15:0] set_vec,
    // stored word
    output reg [15:0] value
);

// ------------------------------------------------------------
// storage: set beats write, unimplemented bits stay zero
// ------------------------------------------------------------
always @(posedge clock)
begin
    if (!rst_n)
        value <= `RESET_WORD;
    else if (wr_en)
        value <= (wr_data | set_vec) & IMPL;
    else
        value <= (value | set_vec) & IMPL;
end

endmodule

`default_nettype wire

// >>> hw/irq_pin_sync.v
`timescale 1ns/1ps
`default_nettype none

module irq_pin_sync
(
    // clock and reset
    input wire clock,
    input wire rst_n,
    // asynchronous pin level
    input wire pin,
    // one-cycle pulse on a rising pin edge
    output reg rise
);

reg meta_q;
reg stable_q;
reg prev_q;

// ------------------------------------------------------------
// two-stage synchroniser, then edge detect on the settled level
// ------------------------------------------------------------
always @(posedge clock)
begin
    if (!rst_n)
    begin
        meta_q <= 1'b0;
        stable_q <= 1'b0;
        prev_q <= 1'b0;
        rise <= 1'b0;
    end
    else
    begin
        meta_q <= pin;
        stable_q <= meta_q;
        prev_q <= stable_q;
        rise <= stable_q & ~prev_q;
    end
end

endmodule

`default_nettype wire
